// >>> rsc_regs.sv
// AHB-Lite register bank for synthesizer calibration, tuning and radio status
//
// Function
// - Coarse tuning register holds 6 writable bits; top two bits read zero.
// - Written calibration results drive the synthesizer for the next frequency; a write landing in a cal_done cycle is dropped for the new result.
// - Calibration control register holds 7 writable bits; bit 7 reads zero.
// - Analog test bit 1 (reset one) includes oscillator selection calibration stage.
// - Output power register is 8-bit read/write, reset zero.
// - Read-only chip identifiers: 8-bit part code and 8-bit revision, each in its own register.
// - Offset estimate is read-only signed 8-bit demodulator value, reset zero.
// - Link quality bit 7 shows last checksum match; cleared on receive entry, except that a crc_done in that cycle loads crc_match instead.
// - Checksum flag reads one while checking is disabled.
// - Link quality bits 6:0 hold read-only estimate over 64 symbols, reset zero.
`timescale 1ns/1ps

module rsc_regs
    import rsc_pkg::*;
(
    input  wire logic           hclk,       // System clock
    input  wire logic           hresetn,    // Async reset, active low
    input  wire logic           hsel,       // Slave select
    input  wire logic [31:0]    haddr,      // Byte address
    input  wire logic [1:0]     htrans,     // Transfer type
    input  wire logic           hwrite,     // Write when high
    input  wire logic [2:0]     hsize,      // Transfer size, word only
    input  wire logic [31:0]    hwdata,     // Write data
    input  wire logic           hready,     // Bus ready in
    output logic      [31:0]    hrdata,     // Read data
    output logic                hreadyout,  // Slave ready out
    output logic                hresp,      // Always OKAY
    input  wire rsc_radio_in_t  radio_in,   // Radio core status
    output rsc_synth_cfg_t      synth_cfg,  // Settings to synthesizer
    output logic                irq         // Level interrupt
);

    // ==========================================================
    // Address decode
    // High when the byte address falls on a mapped word
    function automatic logic addr_mapped(input logic [31:0] a);
        logic [15:0] idx;
        logic        hit;
        idx = a[17:2];
        hit = 1'b0;
        if (a[31:18] != 14'h0000 || a[1:0] != 2'h0) begin
            hit = 1'b0;
        end else if (idx == IDX_VCO_COARSE_CAL || idx == IDX_SYNTH_CAL_CTRL) begin
            hit = 1'b1;
        end else if (idx == IDX_SENS_TUNE_A || idx == IDX_SENS_TUNE_B || idx == IDX_ANALOG_TEST) begin
            hit = 1'b1;
        end else if (idx == IDX_OUTPUT_POWER || idx == IDX_PART_CODE || idx == IDX_REVISION_CODE) begin
            hit = 1'b1;
        end else if (idx == IDX_OFFSET_ESTIMATE || idx == IDX_LINK_QUALITY) begin
            hit = 1'b1;
        end else if (idx == IDX_IRQ_STATUS || idx == IDX_IRQ_MASK) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    // ==========================================================
    // Declarations
    logic             accept;
    logic             wr_pend_q;
    logic [15:0]      wr_idx_q;
    logic             rd_pend_q;
    logic [15:0]      rd_idx_q;
    logic [31:0]      hrdata_q;
    logic             hreadyout_q;
    logic             wr_en;
    logic [7:0]       wbyte;

    logic [5:0]       vco_coarse_cal_q;
    logic [6:0]       synth_cal_ctrl_q;
    logic [7:0]       sens_tune_a_q;
    logic [7:0]       sens_tune_b_q;
    logic [7:0]       analog_test_q;
    logic [7:0]       output_power_q;
    logic [7:0]       offset_est_q;
    logic [7:0]       link_quality;
    logic [IRQ_W-1:0] irq_status_q;
    logic [IRQ_W-1:0] irq_status_d;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [IRQ_W-1:0] irq_events;
    logic             irq_q;
    logic [7:0]       rd_mux;

    // Only word transfers are issued by the master, so hsize needs no decode
    assign accept = hsel & hready & htrans[1];
    assign wr_en  = wr_pend_q;
    assign wbyte  = hwdata[7:0];

    // ==========================================================
    // Bus phase tracking
    // Writes finish with no wait; reads take one wait state so hrdata comes from a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 16'h0000;
            rd_pend_q <= 1'b0;
            rd_idx_q  <= 16'h0000;
        end else begin
            wr_pend_q <= accept & hwrite & addr_mapped(haddr);
            wr_idx_q  <= haddr[17:2];
            rd_pend_q <= accept & ~hwrite;
            rd_idx_q  <= addr_mapped(haddr) ? haddr[17:2] : 16'h0000;
        end
    end

    // Ready drops for the read's first data cycle, then returns with the data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_q <= 1'b1;
        end else if (accept & ~hwrite) begin
            hreadyout_q <= 1'b0;
        end else begin
            hreadyout_q <= 1'b1;
        end
    end

    // ==========================================================
    // Writable calibration registers
    // A calibration result in the same cycle as a write wins: it is the newer tuning
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vco_coarse_cal_q <= RST_VCO_COARSE_CAL;
        end else if (radio_in.cal_done) begin
            vco_coarse_cal_q <= radio_in.cal_coarse;
        end else if (wr_en && wr_idx_q == IDX_VCO_COARSE_CAL) begin
            vco_coarse_cal_q <= wbyte[5:0];
        end
    end

    // Calibration control; bit 7 has no storage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            synth_cal_ctrl_q <= RST_SYNTH_CAL_CTRL;
        end else if (wr_en && wr_idx_q == IDX_SYNTH_CAL_CTRL) begin
            synth_cal_ctrl_q <= wbyte[6:0];
        end
    end

    // ==========================================================
    // Tuning, test and power registers
    // Recommended values are software's job; the hardware stores any byte
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sens_tune_a_q  <= RST_SENS_TUNE_A;
            sens_tune_b_q  <= RST_SENS_TUNE_B;
            analog_test_q  <= RST_ANALOG_TEST;
            output_power_q <= RST_OUTPUT_POWER;
        end else if (wr_en) begin
            if (wr_idx_q == IDX_SENS_TUNE_A) begin
                sens_tune_a_q <= wbyte;
            end else if (wr_idx_q == IDX_SENS_TUNE_B) begin
                sens_tune_b_q <= wbyte;
            end else if (wr_idx_q == IDX_ANALOG_TEST) begin
                analog_test_q <= wbyte;
            end else if (wr_idx_q == IDX_OUTPUT_POWER) begin
                output_power_q <= wbyte;
            end
        end
    end

    // ==========================================================
    // Demodulator status
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            offset_est_q <= RST_OFFSET_ESTIMATE;
        end else if (radio_in.est_valid) begin
            offset_est_q <= radio_in.est_value;
        end
    end

    // Link quality byte with its checksum flag
    rsc_link_quality u_link_quality (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .rx_enter     (radio_in.rx_enter),
        .crc_done     (radio_in.crc_done),
        .crc_match    (radio_in.crc_match),
        .crc_check_en (radio_in.crc_check_en),
        .lqi_valid    (radio_in.lqi_valid),
        .lqi_value    (radio_in.lqi_value),
        .link_quality (link_quality)
    );

    // ==========================================================
    // Interrupt status and mask
    assign irq_events[IRQ_CAL_DONE] = radio_in.cal_done;
    assign irq_events[IRQ_CRC_DONE] = radio_in.crc_done;
    assign irq_events[IRQ_LQI_DONE] = radio_in.lqi_valid;

    // Write-one-to-clear; a new event in the clearing cycle keeps its bit set
    always_comb begin
        irq_status_d = irq_status_q;
        if (wr_en && wr_idx_q == IDX_IRQ_STATUS) begin
            irq_status_d = irq_status_d & ~wbyte[IRQ_W-1:0];
        end
        irq_status_d = irq_status_d | irq_events;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status_q <= RST_IRQ;
        end else begin
            irq_status_q <= irq_status_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask_q <= RST_IRQ;
        end else if (wr_en && wr_idx_q == IDX_IRQ_MASK) begin
            irq_mask_q <= wbyte[IRQ_W-1:0];
        end
    end

    // Output registered from the next status so it follows the sticky bits in step
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_status_d & irq_mask_q);
        end
    end

    // ==========================================================
    // Read multiplexer; unused bits and unmapped words read zero
    always_comb begin
        rd_mux = 8'h00;
        if (rd_idx_q == IDX_VCO_COARSE_CAL) begin
            rd_mux = {2'b00, vco_coarse_cal_q};
        end else if (rd_idx_q == IDX_SYNTH_CAL_CTRL) begin
            rd_mux = {1'b0, synth_cal_ctrl_q};
        end else if (rd_idx_q == IDX_SENS_TUNE_A) begin
            rd_mux = sens_tune_a_q;
        end else if (rd_idx_q == IDX_SENS_TUNE_B) begin
            rd_mux = sens_tune_b_q;
        end else if (rd_idx_q == IDX_ANALOG_TEST) begin
            rd_mux = analog_test_q;
        end else if (rd_idx_q == IDX_OUTPUT_POWER) begin
            rd_mux = output_power_q;
        end else if (rd_idx_q == IDX_PART_CODE) begin
            rd_mux = PART_CODE_VALUE;
        end else if (rd_idx_q == IDX_REVISION_CODE) begin
            rd_mux = REVISION_VALUE;
        end else if (rd_idx_q == IDX_OFFSET_ESTIMATE) begin
            rd_mux = offset_est_q;
        end else if (rd_idx_q == IDX_LINK_QUALITY) begin
            rd_mux = link_quality;
        end else if (rd_idx_q == IDX_IRQ_STATUS) begin
            rd_mux = {5'h00, irq_status_q};
        end else if (rd_idx_q == IDX_IRQ_MASK) begin
            rd_mux = {5'h00, irq_mask_q};
        end
    end

    // Data is loaded in the wait cycle and held until the next read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (rd_pend_q) begin
            hrdata_q <= {24'h00_0000, rd_mux};
        end
    end

    // ==========================================================
    // Settings to the synthesizer come straight from their registers
    assign synth_cfg.vco_coarse_cal        = vco_coarse_cal_q;
    assign synth_cfg.synth_cal_ctrl        = synth_cal_ctrl_q;
    assign synth_cfg.sensitivity_tune_a    = sens_tune_a_q;
    assign synth_cfg.sensitivity_tune_b    = sens_tune_b_q;
    assign synth_cfg.analog_test_ctrl      = analog_test_q;
    assign synth_cfg.output_power_entry    = output_power_q;
    assign synth_cfg.osc_select_cal_enable = analog_test_q[ATC_OSC_SEL_BIT];

    assign hrdata    = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp     = 1'b0;
    assign irq       = irq_q;

endmodule // rsc_regs

// >>> rsc_pkg.sv
// Package: offsets, reset values, field positions and carrier types of the radio synth/status register bank
package rsc_pkg;

    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [15:0] IDX_VCO_COARSE_CAL  = 16'hDF1E;
    localparam logic [15:0] IDX_SYNTH_CAL_CTRL  = 16'hDF1F;
    localparam logic [15:0] IDX_SENS_TUNE_A     = 16'hDF23;
    localparam logic [15:0] IDX_SENS_TUNE_B     = 16'hDF24;
    localparam logic [15:0] IDX_ANALOG_TEST     = 16'hDF25;
    localparam logic [15:0] IDX_OUTPUT_POWER    = 16'hDF2E;
    localparam logic [15:0] IDX_PART_CODE       = 16'hDF36;
    localparam logic [15:0] IDX_REVISION_CODE   = 16'hDF37;
    localparam logic [15:0] IDX_OFFSET_ESTIMATE = 16'hDF38;
    localparam logic [15:0] IDX_LINK_QUALITY    = 16'hDF39;
    localparam logic [15:0] IDX_IRQ_STATUS      = 16'hDF50;
    localparam logic [15:0] IDX_IRQ_MASK        = 16'hDF51;

    // ==========================================================
    // Reset values
    localparam logic [5:0]  RST_VCO_COARSE_CAL  = 6'h20;
    localparam logic [6:0]  RST_SYNTH_CAL_CTRL  = 7'h0D;
    localparam logic [7:0]  RST_SENS_TUNE_A     = 8'h88;
    localparam logic [7:0]  RST_SENS_TUNE_B     = 8'h11;
    localparam logic [7:0]  RST_ANALOG_TEST     = 8'h0B;
    localparam logic [7:0]  RST_OUTPUT_POWER    = 8'h00;
    localparam logic [7:0]  RST_OFFSET_ESTIMATE = 8'h00;
    localparam logic [6:0]  RST_LINK_QUALITY    = 7'h00;

    // Identity values: arbitrary, chosen only to be recognisable
    localparam logic [7:0]  PART_CODE_VALUE     = 8'hA5;
    localparam logic [7:0]  REVISION_VALUE      = 8'h01;

    // ==========================================================
    // Field positions and widths
    localparam int          ATC_OSC_SEL_BIT     = 1;
    localparam int          LQ_CRC_BIT          = 7;
    localparam int          IRQ_W               = 3;
    localparam int          IRQ_CAL_DONE        = 0;
    localparam int          IRQ_CRC_DONE        = 1;
    localparam int          IRQ_LQI_DONE        = 2;
    localparam logic [IRQ_W-1:0] RST_IRQ        = 3'h0;

    // ==========================================================
    // Status and results arriving from the radio core
    typedef struct packed {
        logic       cal_done;              // Calibration finished, pulse
        logic [5:0] cal_coarse;            // Coarse tuning result
        logic       rx_enter;              // Receive mode entered or restarted, pulse
        logic       crc_done;              // Checksum comparison finished, pulse
        logic       crc_match;             // Comparison result
        logic       crc_check_en;          // Checksum checking enabled
        logic       legacy_format_enable;  // Legacy packet format selected
        logic       est_valid;             // Offset estimate update, pulse
        logic [7:0] est_value;             // Offset estimate, two's complement
        logic       lqi_valid;             // Link quality update, pulse
        logic [6:0] lqi_value;             // Link quality estimate
    } rsc_radio_in_t;

    // Settings driven to the synthesizer and analog front end
    typedef struct packed {
        logic [5:0] vco_coarse_cal;        // Coarse tuning value in use
        logic [6:0] synth_cal_ctrl;        // Calibration control
        logic [7:0] sensitivity_tune_a;    // Sensitivity tuning A
        logic [7:0] sensitivity_tune_b;    // Sensitivity tuning B
        logic [7:0] analog_test_ctrl;      // Analog test control
        logic [7:0] output_power_entry;    // PA output level
        logic       osc_select_cal_enable; // Include oscillator selection stage
    } rsc_synth_cfg_t;

endpackage

// >>> rsc_link_quality.sv
// Link quality register: checksum-match flag and demodulation-ease estimate
`timescale 1ns/1ps

module rsc_link_quality
    import rsc_pkg::*;
(
    input  wire logic       hclk,          // System clock
    input  wire logic       hresetn,       // Async reset, active low
    input  wire logic       rx_enter,      // Receive entered or restarted
    input  wire logic       crc_done,      // Checksum compared
    input  wire logic       crc_match,     // Comparison matched
    input  wire logic       crc_check_en,  // Checksum checking on
    input  wire logic       lqi_valid,     // New estimate present
    input  wire logic [6:0] lqi_value,     // Estimate from demodulator
    output logic      [7:0] link_quality   // Register read value
);

    logic       crc_flag_q;
    logic [6:0] lqi_q;

    // ==========================================================
    // Checksum flag: a result in the same cycle as the clear wins, so it is not lost
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            crc_flag_q <= 1'b0;
        end else if (crc_done) begin
            crc_flag_q <= crc_match;
        end else if (rx_enter) begin
            crc_flag_q <= 1'b0;
        end
    end

    // Estimate over the 64 symbols after sync is computed upstream; held here
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lqi_q <= RST_LINK_QUALITY;
        end else if (lqi_valid) begin
            lqi_q <= lqi_value;
        end
    end

    // With checking off the flag must show one regardless of history
    assign link_quality = {(crc_flag_q | ~crc_check_en), lqi_q};

endmodule // rsc_link_quality

// >>> rsc_regs_props.sv
// Checker: bus answer and radio status properties of the register bank
`timescale 1ns/1ps

module rsc_regs_props
    import rsc_pkg::*;
(
    input wire logic           hclk,      // System clock
    input wire logic           hresetn,   // Async reset, active low
    input wire logic           hsel,      // Slave select
    input wire logic [31:0]    haddr,     // Byte address
    input wire logic [1:0]     htrans,    // Transfer type
    input wire logic           hwrite,    // Write when high
    input wire logic [2:0]     hsize,     // Transfer size
    input wire logic [31:0]    hwdata,    // Write data
    input wire logic           hready,    // Bus ready in
    input wire logic [31:0]    hrdata,    // Read data
    input wire logic           hreadyout, // Slave ready out
    input wire logic           hresp,     // Response
    input wire rsc_radio_in_t  radio_in,  // Radio core status
    input wire rsc_synth_cfg_t synth_cfg, // Synthesizer settings
    input wire logic           irq        // Interrupt
);
    default clocking dc @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ==========================================================
    // Helpers: index of the read in flight, held until its data returns
    logic        rd_take;
    logic        wr_take;
    logic [15:0] ra_q;
    assign rd_take = hsel && hready && htrans[1] && !hwrite;
    assign wr_take = hsel && hready && htrans[1] && hwrite;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            ra_q <= 16'h0000;
        else if (rd_take)
            ra_q <= haddr[17:2];
    end

    // ==========================================================
    // Properties; read data is judged when hreadyout comes back
    property p_osc_sel;
        synth_cfg.osc_select_cal_enable == synth_cfg.analog_test_ctrl[ATC_OSC_SEL_BIT];
    endproperty
    a_osc_sel: assert property (p_osc_sel)
        else $error("oscillator stage enable differs from test bit");
    property p_cal_load;
        radio_in.cal_done |=> synth_cfg.vco_coarse_cal == $past(radio_in.cal_coarse);
    endproperty
    a_cal_load: assert property (p_cal_load)
        else $error("calibration result not driven to synthesizer");
    property p_power_hold;
        !$past(wr_take, 2) |-> $stable(synth_cfg.output_power_entry);
    endproperty
    a_power_hold: assert property (p_power_hold)
        else $error("power setting changed without a write");
    property p_part;
        $rose(hreadyout) && ra_q == IDX_PART_CODE |-> hrdata == {24'h000000, PART_CODE_VALUE};
    endproperty
    a_part: assert property (p_part)
        else $error("part code read wrong");
    property p_rev;
        $rose(hreadyout) && ra_q == IDX_REVISION_CODE |-> hrdata == {24'h000000, REVISION_VALUE};
    endproperty
    a_rev: assert property (p_rev)
        else $error("revision read wrong");
    property p_crc_off;
        $rose(hreadyout) && ra_q == IDX_LINK_QUALITY && !$past(radio_in.crc_check_en) |-> hrdata[LQ_CRC_BIT];
    endproperty
    a_crc_off: assert property (p_crc_off)
        else $error("match flag low while checking is off");
    property p_coarse_top;
        $rose(hreadyout) && ra_q == IDX_VCO_COARSE_CAL |-> hrdata[7:6] == 2'b00;
    endproperty
    a_coarse_top: assert property (p_coarse_top)
        else $error("coarse tuning unused bits not zero");
    property p_ctrl_top;
        $rose(hreadyout) && ra_q == IDX_SYNTH_CAL_CTRL |-> !hrdata[7];
    endproperty
    a_ctrl_top: assert property (p_ctrl_top)
        else $error("calibration control bit 7 not zero");
    property p_upper_zero;
        $rose(hreadyout) |-> hrdata[31:8] == 24'h000000;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("read data upper bits not zero");
    property p_rd_wait;
        rd_take |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait)
        else $error("read did not take exactly one wait cycle");
endmodule // rsc_regs_props

bind rsc_regs rsc_regs_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .radio_in(radio_in), .synth_cfg(synth_cfg), .irq(irq));

// >>> test_radio_synth_cal_and_status_regs.sv
// Testbench: reset values, access kinds, radio status and interrupt of the register bank
`timescale 1ns/1ps

module test_radio_synth_cal_and_status_regs
    import rsc_pkg::*;
;
    logic           hclk, hresetn, hsel, hwrite;
    logic [31:0]    haddr, hwdata;
    logic [1:0]     htrans;
    logic [2:0]     hsize;
    wire logic [31:0] hrdata;
    wire logic      hreadyout, hresp, irq;
    rsc_radio_in_t  rin;
    rsc_synth_cfg_t cfg;
    int             n_errors, n_compared;
    logic [31:0]    exp_q[$];
    bit             rd_dp;
    // Register table: index, reset value, writable bits
    localparam logic [15:0] RI[10] = '{IDX_VCO_COARSE_CAL, IDX_SYNTH_CAL_CTRL, IDX_SENS_TUNE_A, IDX_SENS_TUNE_B,
        IDX_ANALOG_TEST, IDX_OUTPUT_POWER, IDX_PART_CODE, IDX_REVISION_CODE, IDX_OFFSET_ESTIMATE, IDX_LINK_QUALITY};
    localparam logic [7:0] RV[10] = '{{2'b00, RST_VCO_COARSE_CAL}, {1'b0, RST_SYNTH_CAL_CTRL}, RST_SENS_TUNE_A,
        RST_SENS_TUNE_B, RST_ANALOG_TEST, RST_OUTPUT_POWER, PART_CODE_VALUE, REVISION_VALUE, 8'h00, 8'h00};
    localparam logic [7:0] RM[10] = '{8'h3F, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};

    // Single slave, so its ready feeds the bus ready
    rsc_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .radio_in(rin), .synth_cfg(cfg), .irq(irq));

    // 20 MHz clock
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    // ==========================================================
    // Reporting and comparison
    task automatic report_and_stop;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic mismatch(input string m);
        n_errors++;
        $display("BAD %0t %s", $time, m);
    endtask
    task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) mismatch($sformatf("read %h expected %h", g, e));
    endtask
    task automatic cmp_v(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) mismatch($sformatf("output %h expected %h", g, e));
    endtask

    // ==========================================================
    // Bus master: entered just after a rising edge, holds each phase until ready
    task automatic bus(input logic w, input logic [15:0] i, input logic [7:0] d, input logic [31:0] e);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {14'h0000, i, 2'b00};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= {24'h000000, d};
        if (!w) exp_q.push_back(e);
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    task automatic wr(input logic [15:0] i, input logic [7:0] d);
        bus(1'b1, i, d, 32'h00000000);
    endtask
    task automatic rd(input logic [15:0] i, input logic [7:0] e);
        bus(1'b0, i, 8'h00, {24'h000000, e});
    endtask
    // Radio pulses last one cycle: the caller raises them, this drops them
    task automatic tick;
        @(posedge hclk);
        rin.cal_done <= 1'b0;
        rin.rx_enter <= 1'b0;
        rin.crc_done <= 1'b0;
        rin.est_valid <= 1'b0;
        rin.lqi_valid <= 1'b0;
    endtask

    // Read data watcher: oldest note against each returned word
    always @(posedge hclk) begin
        if (rd_dp && hreadyout === 1'b1) begin
            rd_dp = 1'b0;
            if (exp_q.size() == 0) mismatch("read data with no note");
            else cmp_rd(hrdata, exp_q.pop_front());
            cmp_v({7'h00, hresp}, 8'h00);
        end
        if (hsel && htrans[1] && hreadyout && !hwrite) rd_dp = 1'b1;
    end

    // Watchdog, far beyond the few hundred cycles the sequence needs
    initial begin
        repeat (5000) @(posedge hclk);
        mismatch("timeout");
        report_and_stop;
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [7:0] d;
        int         i;
        {hresetn, hsel, hwrite, haddr, hwdata, htrans} = '0;
        hsize = 3'b010;
        rin = '0;
        rin.crc_check_en = 1'b1;
        rin.legacy_format_enable = 1'b1;
        d = $urandom(32'h71AA);
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        cmp_v({1'b0, cfg.synth_cal_ctrl}, {1'b0, RST_SYNTH_CAL_CTRL});
        cmp_v(cfg.output_power_entry, RST_OUTPUT_POWER);
        for (i = 0; i < 10; i++) rd(RI[i], RV[i]);
        // Random writes: writable bits land, read-only places keep their value
        for (i = 0; i < 10; i++) begin
            d = $urandom;
            wr(RI[i], d);
            rd(RI[i], (d & RM[i]) | (RV[i] & ~RM[i]));
        end
        wr(16'hDF20, 8'hFF);
        rd(16'hDF20, 8'h00);
        wr(IDX_SENS_TUNE_A, 8'h81);
        wr(IDX_SENS_TUNE_B, 8'h31);
        @(posedge hclk);
        cmp_v(cfg.sensitivity_tune_a, 8'h81);
        cmp_v(cfg.sensitivity_tune_b, 8'h31);
        wr(IDX_SENS_TUNE_B, 8'h35);
        rd(IDX_SENS_TUNE_B, 8'h35);
        // Oscillator stage enable follows test bit 1 both ways
        for (i = 0; i < 2; i++) begin
            wr(IDX_ANALOG_TEST, {6'h02, i[0], 1'b1});
            @(posedge hclk);
            cmp_v({7'h00, cfg.osc_select_cal_enable}, {7'h00, i[0]});
            cmp_v(cfg.analog_test_ctrl, {6'h02, i[0], 1'b1});
        end
        // Calibration result, then a saved value written back for the next hop
        d = $urandom;
        rin.cal_coarse <= d[5:0];
        rin.cal_done <= 1'b1;
        tick;
        rd(IDX_VCO_COARSE_CAL, {2'b00, d[5:0]});
        wr(IDX_VCO_COARSE_CAL, ~d);
        @(posedge hclk);
        cmp_v({2'b00, cfg.vco_coarse_cal}, {2'b00, ~d[5:0]});
        // Negative offset estimate; a write to it must not land
        rin.est_value <= 8'h80;
        rin.est_valid <= 1'b1;
        tick;
        wr(IDX_OFFSET_ESTIMATE, 8'h11);
        rd(IDX_OFFSET_ESTIMATE, 8'h80);
        // Link quality: match, receive restart, checking off, mismatch
        d = $urandom;
        rin.lqi_value <= d[6:0];
        rin.lqi_valid <= 1'b1;
        rin.crc_match <= 1'b1;
        rin.crc_done <= 1'b1;
        tick;
        rd(IDX_LINK_QUALITY, {1'b1, d[6:0]});
        rin.rx_enter <= 1'b1;
        tick;
        rd(IDX_LINK_QUALITY, {1'b0, d[6:0]});
        rin.crc_check_en <= 1'b0;
        @(posedge hclk);
        rd(IDX_LINK_QUALITY, {1'b1, d[6:0]});
        rin.crc_check_en <= 1'b1;
        rin.crc_match <= 1'b0;
        rin.crc_done <= 1'b1;
        tick;
        rd(IDX_LINK_QUALITY, {1'b0, d[6:0]});
        // Interrupt: sticky status, masked off, masked in, cleared by ones
        rd(IDX_IRQ_STATUS, 8'h07);
        cmp_v({7'h00, irq}, 8'h00);
        wr(IDX_IRQ_MASK, 8'h02);
        wr(IDX_IRQ_STATUS, 8'h05);
        repeat (2) @(posedge hclk);
        cmp_v({7'h00, irq}, 8'h01);
        rd(IDX_IRQ_STATUS, 8'h02);
        wr(IDX_IRQ_STATUS, 8'h02);
        repeat (2) @(posedge hclk);
        cmp_v({7'h00, irq}, 8'h00);
        rd(IDX_IRQ_MASK, 8'h02);
        repeat (4) @(posedge hclk);
        report_and_stop;
    end
endmodule // test_radio_synth_cal_and_status_regs
